/* File: src/ipog_regs.svh */
// Timing constants and functional notes for the interleave phase and overvoltage guard
// Functional notes
// - Channel two clock lags channel one by 180 degrees when the option reads 1, else 240.
// - The sync output lags channel one by 90 degrees with option 1, or 120 with option 0.
// - A chain of controllers runs free or follows the predecessor's sync output, no clock needed.
// - A high side port overvoltage alarm kills all gate drives and soft start until it clears.
// - A low side port overvoltage alarm kills all gate drives and soft start until removed.
// - The low side alarm is ignored in boost, the high side alarm counts in both directions.
// - Each alarm must persist for the 5 us filter time before it acts.
// - Channel one, channel two and sync output share one switching frequency.
`ifndef IPOG_REGS_SVH
`define IPOG_REGS_SVH
`define IPOG_CLK_NS        100
`define IPOG_FILT_NS       5000
`define IPOG_FILT_CYC      ((`IPOG_FILT_NS + `IPOG_CLK_NS - 1) / `IPOG_CLK_NS)
`define IPOG_PERIOD_DEF    12'h0064
`define IPOG_PHASE_180     12'h00b4
`define IPOG_PHASE_240     12'h00f0
`define IPOG_PHASE_90      12'h005a
`define IPOG_PHASE_120     12'h0078
`define IPOG_DEG_FULL      12'h0168
`define IPOG_PULSE_DIV     12'h0004
`endif

/* File: src/ipog_pkg.sv */
// Types for the interleave phase and overvoltage guard
package ipog_pkg;
    typedef struct packed {
        logic ch1;
        logic ch2;
        logic sync;
    } ipog_clocks_t;
    typedef struct packed {
        logic hs1;
        logic ls1;
        logic hs2;
        logic ls2;
    } ipog_gates_t;
    typedef enum logic [1:0] {IPOG_RUN, IPOG_FAULT} ipog_state_t;
endpackage

/* File: src/ipog_top.sv */
// Interleaved clock generator and overvoltage gate guard
`timescale 1ns/100ps
`default_nettype none
`include "ipog_regs.svh"
module ipog_top (
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  phase_option_select_i,
    input  wire logic                  sync_clock_in_i,
    input  wire logic                  ext_sync_en_i,
    input  wire logic                  boost_mode_i,
    input  wire logic                  hv_overvoltage_sense_i,
    input  wire logic                  lv_overvoltage_sense_i,
    input  wire ipog_pkg::ipog_gates_t gate_req_i,
    input  wire logic [11:0]           period_i,
    output var  ipog_pkg::ipog_clocks_t clocks_o,
    output var  ipog_pkg::ipog_gates_t  gates_o,
    output logic                       soft_start_reset_o,
    output logic                       ov_fault_o
);
    import ipog_pkg::*;

    // Two-flop synchronisers for the option, sync in, sync enable and both sense inputs; boost mode is used unsynchronised
    logic [4:0] meta_r;
    logic [4:0] sync_r;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_r <= 5'h00;
            sync_r <= 5'h00;
        end else begin
            meta_r <= {phase_option_select_i, sync_clock_in_i, ext_sync_en_i,
                       hv_overvoltage_sense_i, lv_overvoltage_sense_i};
            sync_r <= meta_r;
        end
    end
    logic opt_s, sin_s, ext_s, hv_s, lv_s;
    assign {opt_s, sin_s, ext_s, hv_s, lv_s} = sync_r;

    logic sin_d_r;
    always_ff @(posedge clk_i) begin
        if (srst_i) sin_d_r <= 1'b0;
        else sin_d_r <= sin_s;
    end
    wire sin_rise = sin_s & ~sin_d_r;

    // Period counter; an external sync edge restarts the cycle
    // A shorter period of 4 or more takes effect at once and wraps the count early
    logic [11:0] per_r;
    logic [11:0] cnt_r;
    always_ff @(posedge clk_i) begin
        if (srst_i) per_r <= `IPOG_PERIOD_DEF;
        else if (period_i >= `IPOG_PULSE_DIV) per_r <= period_i;
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) cnt_r <= 12'h0000;
        else if ((ext_s && sin_rise) || cnt_r >= per_r - 12'h0001) cnt_r <= 12'h0000;
        else cnt_r <= cnt_r + 12'h0001;
    end

    // Degrees to counter offset; truncates to whole cycles
    function automatic logic [11:0] deg_off(input logic [11:0] deg, input logic [11:0] per);
        logic [23:0] prod;
        prod = deg * per;
        deg_off = 12'(prod / 24'(`IPOG_DEG_FULL));
    endfunction

    logic [11:0] off2, offs;
    assign off2 = deg_off(opt_s ? `IPOG_PHASE_180 : `IPOG_PHASE_240, per_r);
    assign offs = deg_off(opt_s ? `IPOG_PHASE_90 : `IPOG_PHASE_120, per_r);

    // Pulse is high for the first quarter period after its phase point
    function automatic logic in_pulse(input logic [11:0] c, input logic [11:0] off,
                                      input logic [11:0] per);
        logic [11:0] rel;
        rel = (c >= off) ? c - off : c + per - off;
        in_pulse = rel < per / `IPOG_PULSE_DIV;
    endfunction

    always_ff @(posedge clk_i) begin
        if (srst_i) clocks_o <= '0;
        else begin
            clocks_o.ch1  <= in_pulse(cnt_r, 12'h0000, per_r);
            clocks_o.ch2  <= in_pulse(cnt_r, off2, per_r);
            clocks_o.sync <= in_pulse(cnt_r, offs, per_r);
        end
    end

    // Glitch filters: alarm must hold for the full filter time
    logic [1:0] alarm_raw;
    wire  logic [1:0] alarm_r;
    assign alarm_raw = {hv_s, lv_s & ~boost_mode_i};
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_filt
            // Any dropout restarts the count, so chatter never trips
            logic [5:0] fcnt_r;
            logic       flt_r;
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    fcnt_r <= 6'h00;
                    flt_r  <= 1'b0;
                end else if (!alarm_raw[g]) begin
                    fcnt_r <= 6'h00;
                    flt_r  <= 1'b0;
                end else if (fcnt_r >= 6'(`IPOG_FILT_CYC - 1)) begin
                    flt_r <= 1'b1;
                end else begin
                    fcnt_r <= fcnt_r + 6'h01;
                end
            end
            assign alarm_r[g] = flt_r;
        end
    endgenerate

    ipog_state_t st_r;
    ipog_state_t st_nxt;
    // Fault holds while any filtered alarm stands; restart once all clear
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            IPOG_RUN: begin
                if (|alarm_r) st_nxt = IPOG_FAULT;
            end
            IPOG_FAULT: begin
                if (!(|alarm_r)) st_nxt = IPOG_RUN;
            end
            default: st_nxt = IPOG_RUN;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) st_r <= IPOG_RUN;
        else st_r <= st_nxt;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            gates_o            <= '0;
            soft_start_reset_o <= 1'b1;
            ov_fault_o         <= 1'b0;
        end else begin
            gates_o            <= (st_nxt == IPOG_FAULT) ? '0 : gate_req_i;
            soft_start_reset_o <= (st_nxt == IPOG_FAULT);
            ov_fault_o         <= (st_nxt == IPOG_FAULT);
        end
    end

    // Protection checks
    a_gate_off_fault: assert property (@(posedge clk_i) disable iff (srst_i)
        alarm_r[1] |=> gates_o == '0 && soft_start_reset_o)
        else $error("gates on during hv alarm");

    a_lv_gate_off: assert property (@(posedge clk_i) disable iff (srst_i)
        alarm_r[0] |=> gates_o == '0)
        else $error("gates on during lv alarm");

    a_boost_lv_ignore: assert property (@(posedge clk_i) disable iff (srst_i)
        boost_mode_i |=> !alarm_r[0])
        else $error("lv alarm used in boost");

    a_filter_min_time: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(alarm_r[1]) |-> $past(hv_s, 8) && $past(hv_s, 49))
        else $error("hv alarm passed too soon");

    a_lv_filter_time: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(alarm_r[0]) |-> $past(lv_s, 1) && $past(lv_s, 49))
        else $error("lv alarm passed too soon");

    a_restart_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        !hv_s && !lv_s |=> ##1 !soft_start_reset_o)
        else $error("soft start held after clear");

    a_sync_path: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(hv_s) |-> $past(hv_overvoltage_sense_i, 2))
        else $error("hv sense skipped synchroniser");

    a_lv_sync_path: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(lv_s) |-> $past(lv_overvoltage_sense_i, 2))
        else $error("lv sense skipped synchroniser");

    a_opt_sync_path: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(opt_s) |-> $past(phase_option_select_i, 2))
        else $error("option skipped synchroniser");

    a_sin_sync_path: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(sin_s) |-> $past(sync_clock_in_i, 2))
        else $error("sync in skipped synchroniser");

    a_fault_flag_set: assert property (@(posedge clk_i) disable iff (srst_i)
        |alarm_r |=> ov_fault_o)
        else $error("fault flag missing");

    a_fault_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        !(|alarm_r) |=> !ov_fault_o && !soft_start_reset_o)
        else $error("fault held without alarm");

    a_gates_pass: assert property (@(posedge clk_i) disable iff (srst_i)
        !(|alarm_r) |=> gates_o == $past(gate_req_i))
        else $error("gates blocked without alarm");

    a_fault_pair: assert property (@(posedge clk_i) disable iff (srst_i)
        ov_fault_o |-> soft_start_reset_o && gates_o == '0)
        else $error("fault without gate kill");

    // Clock phase checks
    a_sync_lock: assert property (@(posedge clk_i) disable iff (srst_i)
        ext_s && sin_rise |=> cnt_r == 12'h0000)
        else $error("sync edge did not restart period");

    a_cnt_wrap: assert property (@(posedge clk_i) disable iff (srst_i)
        cnt_r >= per_r - 12'h0001 |=> cnt_r == 12'h0000)
        else $error("period counter overran");

    a_ch1_start: assert property (@(posedge clk_i) disable iff (srst_i)
        cnt_r == 12'h0000 |=> clocks_o.ch1)
        else $error("ch1 not high at period start");

    a_ch1_low: assert property (@(posedge clk_i) disable iff (srst_i)
        cnt_r == per_r / `IPOG_PULSE_DIV && $stable(per_r) |=> !clocks_o.ch1)
        else $error("ch1 pulse too wide");

    a_ch2_phase: assert property (@(posedge clk_i) disable iff (srst_i)
        cnt_r == off2 && $stable(per_r) |=> clocks_o.ch2)
        else $error("ch2 not high at its phase");

    a_sync_phase: assert property (@(posedge clk_i) disable iff (srst_i)
        cnt_r == offs && $stable(per_r) |=> clocks_o.sync)
        else $error("sync not high at its phase");
endmodule
`default_nettype wire

/* File: tb/ipog_sync_src.sv */
// External sync clock source for the guard bench
`timescale 1ns/100ps
`default_nettype none
module ipog_sync_src (
    input  wire logic run_i,
    output logic      sync_o
);
    // Stands low between bursts, 200 ns pulses every 800 ns
    initial begin
        sync_o = 1'b0;
        forever begin
            #170;
            sync_o = run_i;
            #200;
            sync_o = 1'b0;
            #430;
        end
    end
endmodule
`default_nettype wire

/* File: tb/ipog_top_tb.sv */
// Self-checking bench for the interleave phase and overvoltage guard
`timescale 1ns/100ps
`default_nettype none
module ipog_top_tb;
    import ipog_pkg::*;
    localparam int P = 100;
    logic clk_i = 0, srst_i = 1, phase_option_select = 1, ext_en = 0, run = 0, boost = 0, hv = 0, lv = 0;
    logic [11:0] period = 12'(P);
    logic [3:0] req = 4'ha;
    wire logic sync_w;
    ipog_clocks_t clocks;
    ipog_gates_t gates;
    logic ssr, fault;
    int errors = 0, checked = 0, cyc = 0, n;
    ipog_sync_src u_src (.run_i(run), .sync_o(sync_w));
    ipog_top u_dut (.clk_i(clk_i), .srst_i(srst_i), .phase_option_select_i(phase_option_select),
        .sync_clock_in_i(sync_w), .ext_sync_en_i(ext_en), .boost_mode_i(boost),
        .hv_overvoltage_sense_i(hv), .lv_overvoltage_sense_i(lv), .gate_req_i(req),
        .period_i(period), .clocks_o(clocks), .gates_o(gates),
        .soft_start_reset_o(ssr), .ov_fault_o(fault));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            errors++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask
    task automatic wrap_up();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Cycles from a ch1 rise to the next rise of bit b
    task automatic gap(input int b, output int k);
        logic [2:0] p;
        p = clocks;
        for (int i = 0; i < 300 && !(clocks[2] & ~p[2]); i++) begin
            p = clocks;
            @(negedge clk_i);
        end
        p = clocks;
        for (k = 0; k < 300 && !(clocks[b] & ~p[b]); k++) begin
            p = clocks;
            @(negedge clk_i);
        end
    endtask
    task automatic alarm(input logic h, l, bst, input int len, input logic ex);
        boost = bst;
        hv = h;
        lv = l;
        repeat (len) @(negedge clk_i);
        check(fault === ex && ssr === ex && gates === ({4{~ex}} & req), "alarm response");
        hv = 0;
        lv = 0;
        repeat (8) @(negedge clk_i);
        check(fault === 1'b0 && ssr === 1'b0 && gates === req, "alarm release");
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (3) @(negedge clk_i);
        check(ssr === 1'b1 && fault === 1'b0 && gates === 4'h0 && clocks === 3'h0, "reset");
        @(negedge clk_i);
        srst_i = 0;
        for (int o = 1; o >= 0; o--) begin
            phase_option_select = o[0];
            repeat (210) @(negedge clk_i);
            gap(1, n);
            check(n == P * (o ? 180 : 240) / 360, "ch2 lag");
            gap(0, n);
            check(n == P * (o ? 90 : 120) / 360, "sync lag");
            gap(2, n);
            check(n == P, "ch1 period");
        end
        $display("test phase done");
        alarm(1, 0, 0, 60, 1);
        alarm(1, 0, 1, 60, 1);
        alarm(0, 1, 0, 60, 1);
        alarm(0, 1, 1, 60, 0);
        alarm(1, 0, 0, 40, 0);
        $display("test alarm done");
        period = 12'h000a;
        ext_en = 1;
        run = 1;
        repeat (40) @(negedge clk_i);
        gap(2, n);
        check(n == 8, "follows sync in");
        $display("test sync done");
        wrap_up();
    end
endmodule
`default_nettype wire
